// ---- core/rtc_pkg.sv ----
// Shared constants and types of the RTC serial target interface.
// Assumes a 100 MHz system clock and a target bus clock that may stop between frames.
package rtc_pkg;
  localparam logic [6:0] TARGET_ADDR  = 7'h32;  // Fixed target address 0110010
  localparam logic [3:0] FMT_WRITE    = 4'h0;   // Only write format; the core writes on any code but 4
  localparam logic [3:0] FMT_READ_NOW = 4'h4;   // Read right after pointer byte
  localparam logic [3:0] PTR_RESET    = 4'hF;   // Pointer value after stop
  localparam logic [7:0] BLOCKED_DATA = 8'hFF;  // Read data after forced release
  localparam logic [3:0] LAST_BIT     = 4'h7;   // Bit count of eighth data bit
  localparam logic [3:0] ACK_BIT      = 4'h8;   // Bit count of acknowledge slot
  localparam int SYS_CLK_KHZ    = 100_000;      // System clock rate in kHz
  localparam int TIMEOUT_MS     = 500;          // Forced release after start, ms
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * SYS_CLK_KHZ;
  // Byte-level state of the link engine
  typedef enum logic [2:0] {LK_ADDR, LK_PTR, LK_WR, LK_RD, LK_IGN} rtc_lk_state_t;
endpackage

// ---- core/rtc_evt_if.sv ----
// Toggle-coded event carried from one clock domain into another.
// Assumes the source flips tog once per event and holds its data until then.
`timescale 1ns/1ps
`default_nettype none
interface rtc_evt_if;
  logic tog;    // Flips once per event, source domain
  logic pulse;  // One-cycle pulse, destination domain
  modport src (output tog);
  modport dst (input tog, output pulse);
endinterface
`default_nettype wire

// ---- core/rtc_sync.sv ----
// Two-flop level synchroniser and toggle-event receiver.
// Assumes inputs come from another clock domain or from pins.
`timescale 1ns/1ps
`default_nettype none
module rtc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {logic [W-1:0] s1; logic [W-1:0] s2;} rtc_sync_st_t;
  rtc_sync_st_t st, next_st;
  // First stage feeds only the second stage
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end
  // Both stages clear to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end
  assign q = st.s2;
endmodule // rtc_sync

module rtc_tog (
  input  wire logic clk,
  input  wire logic rst_n,
  rtc_evt_if.dst    ev
);
  typedef struct packed {logic s1; logic s2; logic s3;} rtc_tog_st_t;
  rtc_tog_st_t st, next_st;
  // Sync the toggle, then compare the two settled stages
  always_comb begin
    next_st.s1 = ev.tog;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end
  assign ev.pulse = st.s2 ^ st.s3;
endmodule // rtc_tog
`default_nettype wire

// ---- core/rtc_i2c_target.sv ----
// Two-wire target interface of a real-time clock: framing, address match, pointer
// and register access. Assumes a register file on sys_clk with combinational read
// data, and SCL wired both to scl_clk and to the pad logic of the bench.
// Function
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - Eight-bit bytes, each acknowledged by receiver
// - Receiver drives ack after eighth clock, releases after ninth
// - Controller nack ends read; device releases SDA
// - First byte: seven address bits, then direction
// - Answer only to target address 0110010
// - Repeated start restarts with new address byte
// - Write byte two: pointer and format code
// - Third byte stored at pointer, then pre-increment
// - Pointer wraps from F to 0
// - Stop sets pointer to F
// - Format 4 starts transmitting immediately
// - Read after start begins at pointer F
// - Timeout after start ends access like stop
// - After timeout: writes nacked, reads return FF
// - Time counters held from start to stop
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_target import rtc_pkg::*; #(
  parameter int TIMEOUT = TIMEOUT_CYCLES  // Shorten for simulation
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  output var  logic [3:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_we,
  input  wire logic [7:0] reg_rdata,
  output var  logic       time_hold
);
  // System-domain state
  typedef struct packed {
    logic        scl_d;       // Synced SCL, one cycle old
    logic        sda_d;       // Synced SDA, one cycle old
    logic        in_frame;    // Between start and stop or timeout
    logic [31:0] tmr;         // Cycles since first start
    logic        start_clr;   // Pulse: resets link engine
    logic        stop_clr;    // Pulse: resets pointer
    logic        blocked;     // Forced release in effect
    logic [3:0]  addr;        // Register file address
    logic [7:0]  wdata;       // Register write data
    logic        we;          // Register write strobe
    logic        fetch_pend;  // Read data valid next cycle
    logic [7:0]  rd_hold;     // Data for the next byte sent
  } rtc_sys_t;
  // Link-domain engine, cleared by every start
  typedef struct packed {
    rtc_lk_state_t st;      // Byte role
    logic [3:0]    cnt;     // Bit within byte, 8 = ack slot
    logic [7:0]    shreg;   // Received bits
    logic          do_ack;  // Drive ack in the coming slot
    logic          tx;      // Current byte is sent by us
    logic          wr_inc;  // Later writes pre-increment
  } rtc_lk_t;
  // Link-domain crossing sources, never cleared by frames
  typedef struct packed {
    logic       fetch_tog;
    logic [3:0] fetch_addr;
    logic       wr_tog;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
  } rtc_xf_t;
  // Falling-edge SDA driver, cleared by every start
  typedef struct packed {
    logic       oe;    // Pulls SDA low
    logic [7:0] txsh;  // Bits being sent, MSB first
  } rtc_drv_t;

  rtc_sys_t   s, next_s;
  rtc_lk_t    lk, next_lk;
  rtc_xf_t    xf, next_xf;
  rtc_drv_t   dv, next_dv;
  logic [3:0] ptr, next_ptr;    // Internal address pointer
  logic [1:0] pin_s;            // Synced {SCL, SDA}
  logic       blocked_s;        // Forced release, link domain
  logic       link_rst_n;       // Engine reset: power-on or start
  logic       ptr_rst_n;        // Pointer reset: power-on, stop or timeout
  logic       start_det;
  logic       stop_det;
  logic       tmo;
  logic [7:0] byte_in;          // Byte completed on this rising edge
  rtc_evt_if  fetch_ev();
  rtc_evt_if  wr_ev();

  // Pins are asynchronous to sys_clk
  rtc_sync #(.W(2)) u_pin_sync (
    .clk   (sys_clk),
    .rst_n (reset_n),
    .d     ({scl_clk, sda_in}),
    .q     (pin_s)
  );
  // Forced release level into the link domain
  rtc_sync #(.W(1)) u_blk_sync (
    .clk   (scl_clk),
    .rst_n (reset_n),
    .d     (s.blocked),
    .q     (blocked_s)
  );
  // Fetch and write requests into the system domain
  rtc_tog u_fetch_rx (
    .clk   (sys_clk),
    .rst_n (reset_n),
    .ev    (fetch_ev.dst)
  );
  rtc_tog u_wr_rx (
    .clk   (sys_clk),
    .rst_n (reset_n),
    .ev    (wr_ev.dst)
  );
  assign fetch_ev.tog = xf.fetch_tog;
  assign wr_ev.tog    = xf.wr_tog;

  // Conditions seen with SCL high on two samples
  assign start_det = pin_s[1] & s.scl_d & s.sda_d & ~pin_s[0];
  assign stop_det  = pin_s[1] & s.scl_d & ~s.sda_d & pin_s[0];
  assign tmo       = s.in_frame && (s.tmr == 32'(TIMEOUT - 1));
  // Resets of the link domain come from registered pulses, so they never glitch
  assign link_rst_n = reset_n & ~s.start_clr;
  assign ptr_rst_n  = reset_n & ~s.stop_clr;

  // System domain: framing, hold, timeout and register access
  always_comb begin
    next_s            = s;
    next_s.scl_d      = pin_s[1];
    next_s.sda_d      = pin_s[0];
    next_s.start_clr  = 1'b0;
    next_s.stop_clr   = 1'b0;
    next_s.we         = 1'b0;
    next_s.fetch_pend = 1'b0;
    if (s.fetch_pend) begin
      next_s.rd_hold = reg_rdata;
    end
    if (s.in_frame) begin
      next_s.tmr = s.tmr + 32'h0000_0001;
    end
    // A write also feeds the read holder, so read-after-write sees it
    if (wr_ev.pulse) begin
      next_s.addr    = xf.wr_addr;
      next_s.wdata   = xf.wr_data;
      next_s.we      = 1'b1;
      next_s.rd_hold = xf.wr_data;
    end else if (fetch_ev.pulse) begin
      next_s.addr       = xf.fetch_addr;
      next_s.fetch_pend = 1'b1;
    end
    if (start_det) begin
      next_s.start_clr = 1'b1;
      next_s.in_frame  = 1'b1;
      // Timer runs from the first start; a repeated start does not rearm it
      if (!s.in_frame) begin
        next_s.tmr = '0;
      end
    end else if (stop_det || tmo) begin
      next_s.in_frame = 1'b0;
      next_s.stop_clr = 1'b1;
      next_s.blocked  = tmo;
      // Prefetch the reset pointer's data for a read right after start
      if (!wr_ev.pulse) begin
        next_s.addr       = PTR_RESET;
        next_s.fetch_pend = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s         <= '0;
      s.scl_d   <= 1'b1;
      s.sda_d   <= 1'b1;
      s.addr    <= PTR_RESET;
      // Fetch register F at once: a read right after power-up sees no stop to prefetch it
      s.fetch_pend <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Link domain, rising SCL: sample bits, decide acks, move the pointer
  assign byte_in = {lk.shreg[6:0], sda_in};
  always_comb begin
    next_lk  = lk;
    next_xf  = xf;
    next_ptr = ptr;
    if (lk.cnt == ACK_BIT) begin
      next_lk.cnt    = 4'h0;
      next_lk.do_ack = 1'b0;
      if (lk.tx) begin
        next_ptr = ptr + 4'h1;
        // Missing ack from the controller ends sending
        if (sda_in) begin
          next_lk.st = LK_IGN;
        end
      end
      next_lk.tx = (next_lk.st == LK_RD);
    end else begin
      next_lk.cnt   = lk.cnt + 4'h1;
      next_lk.shreg = byte_in;
      // Prefetch one byte ahead; the holder is read at the next byte start
      if (lk.tx && lk.cnt == 4'h0) begin
        next_xf.fetch_tog  = ~xf.fetch_tog;
        next_xf.fetch_addr = ptr + 4'h1;
      end
      if (lk.cnt == LAST_BIT) begin
        unique case (lk.st)
          LK_ADDR: begin
            if (byte_in[7:1] == TARGET_ADDR) begin
              next_lk.do_ack = 1'b1;
              next_lk.st     = byte_in[0] ? LK_RD : LK_PTR;
            end else begin
              next_lk.st = LK_IGN;
            end
          end
          LK_PTR: begin
            if (blocked_s) begin
              next_lk.st = LK_IGN;
            end else begin
              next_lk.do_ack     = 1'b1;
              next_ptr           = byte_in[7:4];
              next_lk.wr_inc     = 1'b0;
              next_xf.fetch_tog  = ~xf.fetch_tog;
              next_xf.fetch_addr = byte_in[7:4];
              // Format 4 sends at once; any other code is taken as a write
              next_lk.st = (byte_in[3:0] == FMT_READ_NOW) ? LK_RD : LK_WR;
            end
          end
          LK_WR: begin
            if (blocked_s) begin
              next_lk.st = LK_IGN;
            end else begin
              next_lk.do_ack  = 1'b1;
              next_ptr        = lk.wr_inc ? ptr + 4'h1 : ptr;
              next_lk.wr_inc  = 1'b1;
              next_xf.wr_tog  = ~xf.wr_tog;
              next_xf.wr_addr = next_ptr;
              next_xf.wr_data = byte_in;
            end
          end
          LK_RD, LK_IGN: begin
            next_lk.do_ack = 1'b0;
          end
        endcase
      end
    end
  end
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) lk <= '{st: LK_ADDR, default: '0};
    else lk <= next_lk;
  end
  always_ff @(posedge scl_clk or negedge ptr_rst_n) begin
    if (!ptr_rst_n) ptr <= PTR_RESET;
    else ptr <= next_ptr;
  end
  always_ff @(posedge scl_clk or negedge reset_n) begin
    if (!reset_n) xf <= '0;
    else xf <= next_xf;
  end

  // Link domain, falling SCL: SDA changes only while SCL is low
  always_comb begin
    next_dv    = dv;
    next_dv.oe = 1'b0;
    if (lk.cnt == ACK_BIT) begin
      next_dv.oe = lk.do_ack;
    end else if (lk.tx) begin
      // Holder was filled at least an ack slot earlier, a byte earlier except after format 4, so it is stable here
      if (lk.cnt == 4'h0) begin
        next_dv.txsh = blocked_s ? BLOCKED_DATA : s.rd_hold;
      end else begin
        next_dv.txsh = {dv.txsh[6:0], 1'b1};
      end
      next_dv.oe = ~next_dv.txsh[7];
    end
  end
  always_ff @(negedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) dv <= '0;
    else dv <= next_dv;
  end

  assign sda_out   = 1'b0;  // Open drain: only ever pulls low
  assign sda_oe    = dv.oe;
  assign reg_addr  = s.addr;
  assign reg_wdata = s.wdata;
  assign reg_we    = s.we;
  assign time_hold = s.in_frame;

  property p_start;
    @(posedge sys_clk) disable iff (!reset_n) start_det |=> s.start_clr && time_hold;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    @(posedge sys_clk) disable iff (!reset_n)
      stop_det && !start_det |=> !time_hold && s.stop_clr ##1 !s.stop_clr;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_ptr_reset;
    @(posedge sys_clk) disable iff (!reset_n)
      s.stop_clr && !reg_we |-> reg_addr == PTR_RESET;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("no refetch at F");
  property p_timeout;
    @(posedge sys_clk) disable iff (!reset_n)
      tmo && !start_det |=> s.blocked && !time_hold && s.tmr == 32'(TIMEOUT);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout missed");
  property p_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(time_hold) |-> $past(start_det) && s.tmr == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("hold without start");
  property p_match;
    @(posedge scl_clk) disable iff (!link_rst_n)
      lk.st == LK_ADDR && lk.cnt == LAST_BIT |=>
        lk.do_ack == (lk.shreg[7:1] == TARGET_ADDR) && lk.cnt == ACK_BIT;
  endproperty
  a_match: assert property (p_match) else $error("address ack wrong");
  property p_foreign;
    @(posedge scl_clk) disable iff (!link_rst_n)
      lk.st == LK_IGN |=> !lk.do_ack && !lk.tx;
  endproperty
  a_foreign: assert property (p_foreign) else $error("ack while ignored");
  property p_wrap;
    @(posedge scl_clk) disable iff (!ptr_rst_n || !link_rst_n)
      lk.tx && lk.cnt == ACK_BIT && ptr == 4'hF |=> ptr == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
  property p_blocked_wr;
    @(posedge scl_clk) disable iff (!link_rst_n)
      blocked_s && lk.st == LK_WR && lk.cnt == LAST_BIT |=> !lk.do_ack;
  endproperty
  a_blocked_wr: assert property (p_blocked_wr) else $error("write acked when blocked");
  property p_ack_drive;
    @(negedge scl_clk) disable iff (!link_rst_n)
      lk.cnt == ACK_BIT && lk.do_ack |=> dv.oe ##1 (dv.oe == (lk.tx && !dv.txsh[7]));
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack slot wrong");
endmodule // rtc_i2c_target
`default_nettype wire

// ---- testbench/rtc_i2c_host.sv ----
// Bus controller model for the clock's serial target: makes SCL and drives SDA open drain.
// Assumes the bench resolves SDA as a wired AND with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_host (
  output var  logic scl,       // Bus clock, stands high between frames
  output var  logic sda_pull,  // High while the controller pulls SDA low
  input  wire logic sda        // Resolved SDA level
);
  int h = 15;  // Half period; 30 ns link clock unless a scenario slows it
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Start or repeated start; SCL stays high 50 ns so the target engine can restart
  task automatic start();
    sda_pull = 1'b0;
    #(h);
    scl = 1'b1;
    #(h);
    sda_pull = 1'b1;
    #50;
    scl = 1'b0;
  endtask
  // Stop, then bus free time before anything else; clock stands still after it
  task automatic stop();
    sda_pull = 1'b1;
    #(h);
    scl = 1'b1;
    #50;
    sda_pull = 1'b0;
    #80;
  endtask
  // One clock: SDA changes only while SCL is low, sampled at the rising edge
  task automatic bit_x(input logic b, output logic r);
    sda_pull = ~b;
    #(h);
    scl = 1'b1;
    r = sda;
    #(h);
    scl = 1'b0;
  endtask
  // Byte out MSB first, then the ack slot with SDA released
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Byte in; ack keeps the target sending, nack ends the read
  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask
endmodule // rtc_i2c_host
`default_nettype wire

// ---- testbench/rtc_i2c_target_access_tb_top.sv ----
// Self-checking bench of the clock's serial target: controller model, register file model.
// Assumes the target core and package from core/; forced release shortened to 2000 cycles.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_target_access_tb_top;
  import rtc_pkg::*;
  localparam int TMO = 2000;  // Shortened forced-release time, sys cycles
  logic       sys_clk;         // 100 MHz system clock
  logic       reset_n;         // Async reset, active low
  logic       scl;             // Bus clock from the controller
  logic       sda_pull;        // Controller pulls SDA
  logic       sda_out;         // Target data level, always low
  logic       sda_oe;          // Target pulls SDA
  wire logic  sda_w;           // Resolved SDA with pull-up
  logic [3:0] reg_addr;        // Register file address
  logic [7:0] reg_wdata;       // Register write data
  logic       reg_we;          // Register write strobe
  logic [7:0] reg_rdata;       // Register read data
  logic       time_hold;       // Time counter freeze
  logic [7:0] regs [16];       // Register file model
  int         fails = 0;       // Mismatch count
  int         tests_run = 0;   // Comparison count
  int         cycles = 0;      // Watchdog count
  // Wired AND: either party pulling wins, else the pull-up
  assign sda_w = ~(sda_pull | (sda_oe & ~sda_out));
  assign reg_rdata = regs[reg_addr];
  rtc_i2c_host i_rtc_i2c_host (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));
  rtc_i2c_target #(.TIMEOUT(TMO)) i_rtc_i2c_target (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_clk(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_rdata(reg_rdata), .time_hold(time_hold));
  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Register file: preloaded so every address reads back something distinct
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 8'hA0 + 8'(i);
    end
  end
  always @(posedge sys_clk) begin
    if (reg_we) begin
      regs[reg_addr] <= reg_wdata;
    end
  end
  // Watchdog: the whole run needs well under 10000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // Read straight after power-up, before any stop: must begin at the default pointer F
  task automatic t_read_cold();
    logic       a;
    logic [7:0] d;
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h65, a);
    chk1(a, 1'b1, "cold read address ack");
    i_rtc_i2c_host.rd(1'b0, d);
    chk(d, 8'hA0 + 8'(PTR_RESET), "cold read at F");
    i_rtc_i2c_host.stop();
    $display("test read_cold done");
  endtask
  // Write E, F and one more: the third store must land at address 0
  task automatic t_write_wrap();
    logic a;
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h64, a);
    chk1(a, 1'b1, "own address ack");
    chk1(time_hold, 1'b1, "hold inside frame");
    i_rtc_i2c_host.wr({4'hE, FMT_WRITE}, a);
    chk1(a, 1'b1, "pointer byte ack");
    i_rtc_i2c_host.wr(8'h11, a);
    i_rtc_i2c_host.wr(8'h22, a);
    i_rtc_i2c_host.wr(8'h33, a);
    chk1(a, 1'b1, "data ack");
    i_rtc_i2c_host.stop();
    chk(regs[14], 8'h11, "store at E");
    chk(regs[15], 8'h22, "store at F");
    chk(regs[0], 8'h33, "store after wrap");
    chk1(time_hold, 1'b0, "hold released");
    $display("test write_wrap done");
  endtask
  // Pointer 2 with format 0, repeated start, read 2..4, nack the last
  task automatic t_read_m1();
    logic       a;
    logic [7:0] d;
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h64, a);
    i_rtc_i2c_host.wr(8'h20, a);
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h65, a);
    chk1(a, 1'b1, "read address ack");
    for (int i = 0; i < 3; i++) begin
      i_rtc_i2c_host.rd(i < 2, d);
      chk(d, 8'hA2 + 8'(i), "method one data");
    end
    #5;
    chk1(sda_oe, 1'b0, "released after nack");
    i_rtc_i2c_host.stop();
    $display("test read_m1 done");
  endtask
  // Format 4: data follows the pointer byte at once, across the wrap; slower clock
  task automatic t_read_m2();
    logic       a;
    logic [7:0] d;
    logic [7:0] e [4];
    e = '{8'h11, 8'h22, 8'h33, 8'hA1};
    i_rtc_i2c_host.h = 30;
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h64, a);
    i_rtc_i2c_host.wr({4'hE, FMT_READ_NOW}, a);
    chk1(a, 1'b1, "read-now pointer ack");
    for (int i = 0; i < 4; i++) begin
      i_rtc_i2c_host.rd(i < 3, d);
      chk(d, e[i], "method two data");
    end
    i_rtc_i2c_host.stop();
    i_rtc_i2c_host.h = 15;
    $display("test read_m2 done");
  endtask
  // Read addressed right after start begins at F, left there by the last stop
  task automatic t_read_m3();
    logic       a;
    logic [7:0] d;
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h65, a);
    i_rtc_i2c_host.rd(1'b1, d);
    chk(d, 8'h22, "method three first byte");
    i_rtc_i2c_host.rd(1'b0, d);
    chk(d, 8'h33, "method three wrapped");
    i_rtc_i2c_host.stop();
    $display("test read_m3 done");
  endtask
  // Neighbouring address gets no ack, nor does the rest of the frame
  task automatic t_foreign();
    logic a;
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h66, a);
    chk1(a, 1'b0, "foreign address nack");
    i_rtc_i2c_host.wr(8'h00, a);
    chk1(a, 1'b0, "frame ignored");
    i_rtc_i2c_host.stop();
    $display("test foreign done");
  endtask
  // Stall past the forced release: writes refused, reads give FF, stop restores access
  task automatic t_timeout();
    logic       a;
    logic [7:0] d;
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h64, a);
    i_rtc_i2c_host.wr(8'h30, a);
    #((TMO + 200) * 10);
    chk1(time_hold, 1'b0, "hold dropped by release");
    i_rtc_i2c_host.wr(8'h55, a);
    chk1(a, 1'b0, "write refused");
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h65, a);
    i_rtc_i2c_host.rd(1'b0, d);
    chk(d, BLOCKED_DATA, "blocked read");
    i_rtc_i2c_host.stop();
    chk(regs[3], 8'hA3, "no store while blocked");
    i_rtc_i2c_host.start();
    i_rtc_i2c_host.wr(8'h65, a);
    i_rtc_i2c_host.rd(1'b0, d);
    chk(d, 8'h22, "pointer back at F");
    i_rtc_i2c_host.stop();
    $display("test timeout done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence; the 2.3 ns offset keeps bus events off the system clock edges
  initial begin
    reset_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    #2.3;
    t_read_cold();
    t_write_wrap();
    t_read_m1();
    t_read_m2();
    t_read_m3();
    t_foreign();
    t_timeout();
    final_report();
  end
endmodule // rtc_i2c_target_access_tb_top
`default_nettype wire
